// ---- rnp_defs.svh ----
`ifndef RNP_DEFS_SVH
`define RNP_DEFS_SVH

// minimum low time of the reset input, in ns
`define RNP_RST_MIN_NS 500
// clock period in ns
`define RNP_CLK_NS 25
// reset input low time in cycles, rounded up
`define RNP_RST_MIN_CYC ((`RNP_RST_MIN_NS + `RNP_CLK_NS - 1) / `RNP_CLK_NS)
// internal reset sequence length, in cycles
`define RNP_SEQ_CYC 32
// wake delay from interrupt falling edge in power-down, in cycles
`define RNP_WAKE_CYC 16
// counter width
`define RNP_CNT_W 8
// reset value of configuration bits
`define RNP_CFG_RST 1'b0

`endif

// ---- rnp_pkg.sv ----
package rnp_pkg;
    typedef enum {ST_RUN, ST_SEQ, ST_INIT, ST_PD, ST_WAKE} rnp_state_t;
    typedef struct packed {
        logic bidir_reset_enable;
        logic powerdown_config_bit;
    } rnp_cfg_t;
    typedef struct packed {
        logic sw_reset;
        logic wdt_reset;
        logic powerdown_instruction;
        logic end_of_init_instruction;
    } rnp_cpu_t;
endpackage

// ---- rnp_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module rnp_sync (
    // clock
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // pin
    input wire logic async_i,
    output logic sync_o
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = ce_i ? async_i : meta_q;
        sync_d = ce_i ? meta_q : sync_q;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule // rnp_sync
`default_nettype wire

// ---- rnp_top.sv ----
// Notes on behaviour
// - reset input low long enough with oscillator running resets device
// - with bidirectional reset enabled, device pulls reset line low during sequence after software or watchdog reset, not hardware reset
// - reset indication output goes low on hardware, software or watchdog reset
// - reset indication stays low until end-of-initialization instruction executes
// - falling edge on interrupt input in run state requests the non-maskable trap
// - power-down instruction with config bit 0 enters power-down only if input low
// - power-down instruction with config bit 0 and input high is ignored
// - timing pin selects sync or async reset and times power-down wake
`include "rnp_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module rnp_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic osc_running_i,
    // reset pin
    input wire logic ext_reset_in_i,
    output logic ext_reset_out_o,
    output logic ext_reset_oe_o,
    // interrupt and timing pins
    input wire logic nmi_n_i,
    input wire logic powerdown_timing_pin_i,
    // cpu side
    input wire rnp_pkg::rnp_cfg_t cfg_i,
    input wire rnp_pkg::rnp_cpu_t cpu_i,
    // outputs
    output logic reset_indication_out_n_o,
    output logic core_reset_o,
    output logic async_reset_mode_o,
    output logic nmi_trap_o,
    output logic powerdown_o
);
    logic rst_pin;
    logic nmi_pin;
    logic tpin;
    logic [2:0] pin_async;
    logic [2:0] pin_sync;
    rnp_pkg::rnp_state_t state_q;
    rnp_pkg::rnp_state_t state_d;
    logic [`RNP_CNT_W-1:0] cnt_q;
    logic [`RNP_CNT_W-1:0] cnt_d;
    logic [`RNP_CNT_W-1:0] low_q;
    logic [`RNP_CNT_W-1:0] low_d;
    logic nmi_prev_q;
    logic nmi_prev_d;
    logic trap_q;
    logic trap_d;
    logic rsti_q;
    logic rsti_d;
    logic async_q;
    logic async_d;
    logic bidir_q;
    logic bidir_d;
    logic hw_rst;
    logic any_rst;
    logic nmi_fall;
    logic seq_end;

    // two-stage synchronisers for reset, interrupt and timing pins
    assign pin_async = {powerdown_timing_pin_i, nmi_n_i, ext_reset_in_i};
    generate
        for (genvar gi = 0; gi < 3; gi++) begin : g_sync
            rnp_sync u_sync (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .ce_i(ce_i),
                .async_i(pin_async[gi]),
                .sync_o(pin_sync[gi])
            );
        end
    endgenerate
    assign rst_pin = pin_sync[0];
    assign nmi_pin = pin_sync[1];
    assign tpin = pin_sync[2];

    // low-time filter on reset pin, ignored while the device drives it
    always_comb begin
        low_d = low_q;
        if (!osc_running_i || rst_pin || bidir_q) begin
            low_d = '0;
        end else if (low_q != `RNP_CNT_W'(`RNP_RST_MIN_CYC)) begin
            low_d = low_q + `RNP_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            low_q <= '0;
        end else if (ce_i) begin
            low_q <= low_d;
        end
    end

    assign hw_rst = (low_q == `RNP_CNT_W'(`RNP_RST_MIN_CYC));
    assign any_rst = hw_rst || cpu_i.sw_reset || cpu_i.wdt_reset;
    assign seq_end = (state_q == rnp_pkg::ST_SEQ) && (cnt_q == `RNP_CNT_W'(`RNP_SEQ_CYC - 1));
    assign nmi_fall = nmi_prev_q && !nmi_pin;

    // reset, init and power-down sequencing
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (any_rst) begin
            state_d = rnp_pkg::ST_SEQ;
            cnt_d = '0;
        end else begin
            case (state_q)
                rnp_pkg::ST_SEQ: begin
                    if (seq_end) begin
                        state_d = rnp_pkg::ST_INIT;
                    end else begin
                        cnt_d = cnt_q + `RNP_CNT_W'(1);
                    end
                end
                rnp_pkg::ST_INIT: begin
                    if (cpu_i.end_of_init_instruction) begin
                        state_d = rnp_pkg::ST_RUN;
                    end
                end
                rnp_pkg::ST_RUN: begin
                    if (cpu_i.powerdown_instruction) begin
                        if (cfg_i.powerdown_config_bit || !nmi_pin) begin
                            state_d = rnp_pkg::ST_PD;
                        end
                    end
                end
                rnp_pkg::ST_PD: begin
                    cnt_d = '0;
                    if (nmi_fall) begin
                        state_d = rnp_pkg::ST_WAKE;
                    end
                end
                rnp_pkg::ST_WAKE: begin
                    if (cnt_q == `RNP_CNT_W'(`RNP_WAKE_CYC - 1) && tpin) begin
                        state_d = rnp_pkg::ST_RUN;
                    end else if (cnt_q != `RNP_CNT_W'(`RNP_WAKE_CYC - 1)) begin
                        cnt_d = cnt_q + `RNP_CNT_W'(1);
                    end
                end
                default: state_d = rnp_pkg::ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= rnp_pkg::ST_SEQ;
            cnt_q <= '0;
        end else if (ce_i) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // reset indication, low from any reset until end of initialisation
    always_comb begin
        rsti_d = rsti_q;
        if (any_rst) begin
            rsti_d = 1'b0;
        end else if (state_q == rnp_pkg::ST_INIT && cpu_i.end_of_init_instruction) begin
            rsti_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rsti_q <= 1'b0;
        end else if (ce_i) begin
            rsti_q <= rsti_d;
        end
    end

    // reset mode and pin drive, latched when a reset is taken
    always_comb begin
        async_d = async_q;
        bidir_d = bidir_q;
        if (any_rst) begin
            async_d = !tpin;
            bidir_d = cfg_i.bidir_reset_enable && !hw_rst;
        end else if (seq_end) begin
            bidir_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            async_q <= `RNP_CFG_RST;
            bidir_q <= `RNP_CFG_RST;
        end else if (ce_i) begin
            async_q <= async_d;
            bidir_q <= bidir_d;
        end
    end

    // falling edge of interrupt input
    always_comb begin
        nmi_prev_d = nmi_pin;
        trap_d = nmi_fall && state_q == rnp_pkg::ST_RUN;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            nmi_prev_q <= 1'b1;
            trap_q <= 1'b0;
        end else if (ce_i) begin
            nmi_prev_q <= nmi_prev_d;
            trap_q <= trap_d;
        end
    end

    assign ext_reset_out_o = 1'b0;
    assign ext_reset_oe_o = bidir_q;
    assign reset_indication_out_n_o = rsti_q;
    assign core_reset_o = (state_q == rnp_pkg::ST_SEQ);
    assign async_reset_mode_o = async_q;
    assign nmi_trap_o = trap_q;
    assign powerdown_o = (state_q == rnp_pkg::ST_PD) || (state_q == rnp_pkg::ST_WAKE);
endmodule // rnp_top
`default_nettype wire

// ---- rnp_board.sv ----
`timescale 1ns/100ps
`default_nettype none
module rnp_board (
    // drive requests
    input wire logic oe_i,
    input wire logic pull_low_i,
    input wire logic nmi_low_i,
    // pins
    output logic reset_pin_o,
    output logic nmi_n_o,
    output logic slow_osc_off_bit_o
);
    assign slow_osc_off_bit_o = 1'b1;
    assign reset_pin_o = !(oe_i || pull_low_i);
    assign nmi_n_o = !nmi_low_i;
endmodule // rnp_board
`default_nettype wire

// ---- rnp_top_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module rnp_top_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // inputs
    input wire logic nmi_n_i,
    input wire rnp_pkg::rnp_cfg_t cfg_i,
    input wire rnp_pkg::rnp_cpu_t cpu_i,
    // outputs
    input wire logic ext_reset_out_o,
    input wire logic ext_reset_oe_o,
    input wire logic reset_indication_out_n_o,
    input wire logic core_reset_o,
    input wire logic nmi_trap_o,
    input wire logic powerdown_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence pd_nmi_high;
        nmi_n_i [*4] ##0 cpu_i.powerdown_instruction && !cfg_i.powerdown_config_bit && !powerdown_o;
    endsequence
    a_trap_pulse: assert property (nmi_trap_o |-> !$past(nmi_n_i, 2) ##1 !nmi_trap_o)
        else $error("trap pulse wrong");
    a_ind_release: assert property ($rose(reset_indication_out_n_o) |->
        $past(cpu_i.end_of_init_instruction) || $past(cpu_i.end_of_init_instruction, 2))
        else $error("indication rose early");
    a_core_ind: assert property (core_reset_o |-> !reset_indication_out_n_o)
        else $error("indication high in reset");
    a_oe_core: assert property (ext_reset_oe_o |-> core_reset_o && !ext_reset_out_o)
        else $error("pin driven outside reset");
    a_sw_reset: assert property ((cpu_i.sw_reset || cpu_i.wdt_reset) |-> ##[1:2] core_reset_o)
        else $error("reset not taken");
    a_oe_bidir: assert property ((cpu_i.wdt_reset && cfg_i.bidir_reset_enable) |-> ##[1:2] ext_reset_oe_o)
        else $error("pin not pulled");
    a_pd_refuse: assert property (pd_nmi_high |=> !powerdown_o [*2])
        else $error("power-down not refused");
    a_pd_cause: assert property ($rose(powerdown_o) |-> $past(cpu_i.powerdown_instruction) &&
        (!$past(nmi_n_i, 2) || $past(cfg_i.powerdown_config_bit)))
        else $error("power-down without cause");
endmodule // rnp_top_checker
bind rnp_top rnp_top_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .nmi_n_i(nmi_n_i), .cfg_i(cfg_i),
    .cpu_i(cpu_i), .ext_reset_out_o(ext_reset_out_o), .ext_reset_oe_o(ext_reset_oe_o),
    .reset_indication_out_n_o(reset_indication_out_n_o), .core_reset_o(core_reset_o),
    .nmi_trap_o(nmi_trap_o), .powerdown_o(powerdown_o));
`default_nettype wire

// ---- test_rnp_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_rnp_top;
    logic clk_i = 0, rst_n_i = 0, pull_low = 0, nmi_low = 0, trap_seen = 0;
    logic oe, pin, nmi_n, ind_n, core_rst, pd, trap, out, amode;
    logic tpin = 1, ce = 1, osc = 1;
    rnp_pkg::rnp_cfg_t cfg = '0;
    rnp_pkg::rnp_cpu_t cpu = '0;
    int mismatches = 0, num_checks = 0;
    logic [3:0] rows [3] = '{4'b1011, 4'b0111, 4'b1000}; // sw, wdt, bidir, expected oe
    rnp_board u_board (.oe_i(oe), .pull_low_i(pull_low), .nmi_low_i(nmi_low), .reset_pin_o(pin), .nmi_n_o(nmi_n),
        .slow_osc_off_bit_o());
    rnp_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .osc_running_i(osc), .ext_reset_in_i(pin),
        .ext_reset_out_o(out), .ext_reset_oe_o(oe), .nmi_n_i(nmi_n), .powerdown_timing_pin_i(tpin),
        .cfg_i(cfg), .cpu_i(cpu), .reset_indication_out_n_o(ind_n), .core_reset_o(core_rst),
        .async_reset_mode_o(amode), .nmi_trap_o(trap), .powerdown_o(pd));
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (trap) trap_seen <= 1'b1;
    task chk(input logic s, input logic e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task close_out;
        if (mismatches == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task init_done;
        step(40);
        cpu.end_of_init_instruction = 1'b1;
        step(1);
        cpu = '0;
        step(2);
        chk(ind_n, 1'b1);
    endtask
    initial begin
        #20us;
        mismatches++;
        close_out;
    end
    initial begin
        step(10);
        rst_n_i = 1'b1;
        step(5);
        chk(ind_n, 1'b0);
        init_done;
        foreach (rows[i]) begin
            {cpu.sw_reset, cpu.wdt_reset, cfg.bidir_reset_enable} = rows[i][3:1];
            step(1);
            cpu = '0;
            step(1);
            chk(core_rst, 1'b1);
            chk(oe, rows[i][0]);
            chk(pin, !rows[i][0]);
            step(30);
            chk(ind_n, 1'b0);
            init_done;
        end
        pull_low = 1'b1;
        step(24);
        pull_low = 1'b0;
        step(3);
        chk(core_rst, 1'b1);
        chk(oe, 1'b0);
        init_done;
        cpu.powerdown_instruction = 1'b1;
        step(1);
        cpu = '0;
        step(2);
        chk(pd, 1'b0);
        nmi_low = 1'b1;
        step(3);
        chk(trap, 1'b1);
        step(1);
        chk(trap, 1'b0);
        step(2);
        chk(trap_seen, 1'b1);
        cpu.powerdown_instruction = 1'b1;
        step(1);
        cpu = '0;
        step(2);
        chk(pd, 1'b1);
        tpin = 1'b0;
        nmi_low = 1'b0;
        step(3);
        nmi_low = 1'b1;
        step(25);
        chk(pd, 1'b1);
        tpin = 1'b1;
        step(4);
        chk(pd, 1'b0);
        chk(amode, 1'b0);
        tpin = 1'b0;
        step(3);
        cpu.sw_reset = 1'b1;
        step(1);
        cpu = '0;
        step(2);
        chk(amode, 1'b1);
        chk(out, 1'b0);
        tpin = 1'b1;
        init_done;
        osc = 1'b0;
        pull_low = 1'b1;
        step(24);
        pull_low = 1'b0;
        step(3);
        chk(core_rst, 1'b0);
        osc = 1'b1;
        nmi_low = 1'b0;
        step(4);
        ce = 1'b0;
        nmi_low = 1'b1;
        step(6);
        chk(trap, 1'b0);
        ce = 1'b1;
        step(3);
        chk(trap, 1'b1);
        close_out;
    end
endmodule // test_rnp_top
`default_nettype wire
